// ### rtl/spectral_fifo_pkg.sv
package spectral_fifo_pkg;

  // register map
  localparam logic [7:0] ADDR_FLICKER_CFG = 8'hD7;
  localparam logic [7:0] ADDR_CHAN_SEL    = 8'hFC;
  localparam logic [7:0] ADDR_FILL_LEVEL  = 8'hFD;
  localparam logic [7:0] ADDR_READ_LOW    = 8'hFE;
  localparam logic [7:0] ADDR_READ_HIGH   = 8'hFF;

  // field layout and reset values
  localparam logic [6:0] CFG_FIXED_BITS   = 7'h21;
  localparam logic [7:0] CHAN_SEL_RESET   = 8'h00;
  localparam logic [7:0] CHAN_SEL_MASK    = 8'h7F;
  localparam logic [7:0] ADDR_RESET       = 8'h00;
  localparam int         CFG_FD_BIT       = 7;
  localparam int         SEL_STATUS_BIT   = 0;
  localparam int         SEL_CHAN5_BIT    = 6;
  localparam int         SEL_FLICKER_BIT  = 7;

  // storage geometry
  localparam int ENTRY_W     = 16;
  localparam int RING_DEPTH  = 128;
  localparam int LEVEL_W     = 8;
  localparam int STAGE_DEPTH = 4;
  localparam int NUM_CHAN    = 6;

  // capture items in the order they enter the buffer
  localparam logic [2:0] ITEM_FIRST = 3'h0;
  localparam logic [2:0] ITEM_LAST  = 3'h7;
  localparam logic [2:0] ITEM_STEP  = 3'h1;

  typedef enum logic {
    SEQ_IDLE,
    SEQ_RUN
  } seq_state_t;

endpackage : spectral_fifo_pkg

// ### rtl/stage_fifo.sv
module stage_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input  wire logic             core_clk,
  input  wire logic             resetn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_q;
  logic [PW-1:0]    rd_q;
  logic [PW:0]      count_q;
  logic             push;
  logic             pop;

  assign in_ready  = (count_q != DEPTH[PW:0]);
  assign out_valid = (count_q != '0);
  assign out_data  = mem[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  // depth is a power of two, so pointers wrap by themselves
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wr_q    <= '0;
      rd_q    <= '0;
      count_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop)  rd_q <= rd_q + 1'b1;
      count_q <= count_q + PW'(0) + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
    end
  end

endmodule : stage_fifo

// ### rtl/entry_ring.sv
module entry_ring
  import spectral_fifo_pkg::*;
#(
  parameter int WIDTH = ENTRY_W,
  parameter int DEPTH = RING_DEPTH,
  parameter int LW    = LEVEL_W
) (
  input  wire logic             core_clk,
  input  wire logic             resetn,
  input  wire logic             push,
  input  wire logic [WIDTH-1:0] push_data,
  input  wire logic             pop,
  output logic      [WIDTH-1:0] head,
  output logic      [LW-1:0]    level,
  output logic                  full
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_q;
  logic [PW-1:0]    rd_q;
  logic [LW-1:0]    level_q;
  logic             do_push;
  logic             do_pop;

  assign full    = (level_q == LW'(DEPTH));
  assign do_push = push && !full;
  assign do_pop  = pop && (level_q != '0);
  assign head    = mem[rd_q];
  assign level   = level_q;

  always_ff @(posedge core_clk) begin
    if (do_push) begin
      mem[wr_q] <= push_data;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (do_push) wr_q <= wr_q + 1'b1;
      if (do_pop)  rd_q <= rd_q + 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      level_q <= '0;
    end else if (do_push && !do_pop) begin
      level_q <= level_q + 1'b1;
    end else if (do_pop && !do_push) begin
      level_q <= level_q - 1'b1;
    end
  end

endmodule : entry_ring

// ### rtl/spectral_result_fifo.sv
module spectral_result_fifo
  import spectral_fifo_pkg::*;
#(
  parameter int DEPTH = RING_DEPTH,
  parameter int STAGE = STAGE_DEPTH
) (
  input  wire logic                core_clk,
  input  wire logic                resetn,
  input  wire logic                addr_set,
  input  wire logic [7:0]          addr_in,
  input  wire logic                reg_wr,
  input  wire logic [7:0]          reg_wdata,
  input  wire logic                reg_rd,
  output logic      [7:0]          reg_rdata_q,
  input  wire logic                sample_valid,
  input  wire logic [7:0]          measurement_status_byte,
  input  wire logic [ENTRY_W-1:0]  chan_data [NUM_CHAN],
  input  wire logic [ENTRY_W-1:0]  flicker_raw_data,
  input  wire logic                flicker_detect_enable,
  input  wire logic                overflow_clear,
  output logic                     overflow_flag_q,
  output logic                     buffer_data_interrupt_q,
  output logic                     capture_busy_q
);

  logic [7:0]         addr_ptr_q;
  logic [7:0]         chan_sel_q;
  logic               cfg_fd_q;
  seq_state_t         seq_q;
  logic [2:0]         item_q;
  logic [7:0]         item_sel_q;
  logic [ENTRY_W-1:0] snap_q [8];
  logic               acc_rd;
  logic               acc_any;
  logic               pop_now;
  logic               stage_in_valid;
  logic               stage_in_ready;
  logic               stage_out_valid;
  logic               stage_out_ready;
  logic [ENTRY_W-1:0] stage_out_data;
  logic               drain_fire;
  logic               ring_push;
  logic [ENTRY_W-1:0] ring_head;
  logic [LEVEL_W-1:0] ring_level;
  logic               ring_full;
  logic [7:0]         rdata_d;
  logic [7:0]         sel_d;
  logic               item_done;

  // ---------------- register pointer ----------------

  assign acc_rd  = reg_rd && !addr_set;
  assign acc_any = (reg_rd || reg_wr) && !addr_set;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      addr_ptr_q <= ADDR_RESET;
    end else if (addr_set) begin
      addr_ptr_q <= addr_in;
    end else if (acc_any) begin
      if (addr_ptr_q == ADDR_READ_HIGH) begin
        addr_ptr_q <= ADDR_READ_LOW;
      end else begin
        addr_ptr_q <= addr_ptr_q + 8'h01;
      end
    end
  end

  // ---------------- writable registers ----------------

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      chan_sel_q <= CHAN_SEL_RESET;
    end else if (reg_wr && !addr_set && addr_ptr_q == ADDR_CHAN_SEL) begin
      chan_sel_q <= reg_wdata & CHAN_SEL_MASK;
    end
  end

  // the low seven bits of the flicker config are fixed; writes there
  // are dropped so a careless host cannot disturb them
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cfg_fd_q <= 1'b0;
    end else if (reg_wr && !addr_set && addr_ptr_q == ADDR_FLICKER_CFG) begin
      cfg_fd_q <= reg_wdata[CFG_FD_BIT];
    end
  end

  // ---------------- read side ----------------

  // the entry is consumed on the high byte; a lone low-byte read leaves it
  assign pop_now = acc_rd && addr_ptr_q == ADDR_READ_HIGH
                   && ring_level != '0;

  always_comb begin
    rdata_d = 8'h00;
    case (addr_ptr_q)
      ADDR_FLICKER_CFG: rdata_d = {cfg_fd_q, CFG_FIXED_BITS};
      ADDR_CHAN_SEL:    rdata_d = chan_sel_q;
      ADDR_FILL_LEVEL:  rdata_d = ring_level;
      ADDR_READ_LOW: begin
        if (ring_level != '0) rdata_d = ring_head[7:0];
      end
      ADDR_READ_HIGH: begin
        if (ring_level != '0) rdata_d = ring_head[15:8];
      end
      default:          rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata_q <= 8'h00;
    end else if (acc_rd) begin
      reg_rdata_q <= rdata_d;
    end
  end

  // ---------------- capture sequencer ----------------

  always_comb begin
    sel_d = chan_sel_q;
    sel_d[SEL_STATUS_BIT] = chan_sel_q[SEL_STATUS_BIT];
    sel_d[SEL_CHAN5_BIT] = chan_sel_q[SEL_CHAN5_BIT]
                           && !flicker_detect_enable;
    sel_d[SEL_FLICKER_BIT] = cfg_fd_q && flicker_detect_enable;
  end

  // a sample that arrives while the previous one is still draining is
  // skipped whole; partial sets would desynchronise the host's parsing
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      item_sel_q <= 8'h00;
    end else if (seq_q == SEQ_IDLE && sample_valid) begin
      item_sel_q <= sel_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (seq_q == SEQ_IDLE && sample_valid) begin
      snap_q[0] <= {8'h00, measurement_status_byte};
      for (int i = 0; i < NUM_CHAN; i++) begin
        snap_q[i+1] <= chan_data[i];
      end
      snap_q[7] <= flicker_raw_data;
    end
  end

  assign stage_in_valid = (seq_q == SEQ_RUN) && item_sel_q[item_q];
  assign item_done = (seq_q == SEQ_RUN)
                     && (!item_sel_q[item_q] || stage_in_ready);

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      seq_q  <= SEQ_IDLE;
      item_q <= ITEM_FIRST;
    end else begin
      case (seq_q)
        SEQ_IDLE: begin
          item_q <= ITEM_FIRST;
          if (sample_valid && sel_d != 8'h00) seq_q <= SEQ_RUN;
        end
        SEQ_RUN: begin
          if (item_done) begin
            item_q <= item_q + ITEM_STEP;
            if (item_q == ITEM_LAST) seq_q <= SEQ_IDLE;
          end
        end
        default: seq_q <= SEQ_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      capture_busy_q <= 1'b0;
    end else begin
      capture_busy_q <= (seq_q == SEQ_RUN);
    end
  end

  // ---------------- staging and storage ----------------

  // the ring has one port pair; holding the stage during a pop keeps
  // push and pop from racing on the level in the same cycle
  assign stage_out_ready = !pop_now;
  assign drain_fire = stage_out_valid && stage_out_ready;
  assign ring_push  = drain_fire && !ring_full;

  stage_fifo #(
    .WIDTH (ENTRY_W),
    .DEPTH (STAGE)
  ) u_stage (
    .core_clk  (core_clk),
    .resetn    (resetn),
    .in_valid  (stage_in_valid),
    .in_ready  (stage_in_ready),
    .in_data   (snap_q[item_q]),
    .out_valid (stage_out_valid),
    .out_ready (stage_out_ready),
    .out_data  (stage_out_data)
  );

  entry_ring #(
    .WIDTH (ENTRY_W),
    .DEPTH (DEPTH),
    .LW    (LEVEL_W)
  ) u_ring (
    .core_clk  (core_clk),
    .resetn    (resetn),
    .push      (ring_push),
    .push_data (stage_out_data),
    .pop       (pop_now),
    .head      (ring_head),
    .level     (ring_level),
    .full      (ring_full)
  );

  // set wins over a clear in the same cycle
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      overflow_flag_q <= 1'b0;
    end else if (drain_fire && ring_full) begin
      overflow_flag_q <= 1'b1;
    end else if (overflow_clear) begin
      overflow_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      buffer_data_interrupt_q <= 1'b0;
    end else begin
      buffer_data_interrupt_q <= (ring_level != '0);
    end
  end

  // ---------------- checks ----------------

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  addr_wrap_a: assert property (
    acc_any && addr_ptr_q == ADDR_READ_HIGH |=> addr_ptr_q == ADDR_READ_LOW)
    else $error("pointer did not wrap to low read port");

  pop_on_high_a: assert property (
    ring_level < $past(ring_level) |->
      $past(acc_rd && addr_ptr_q == ADDR_READ_HIGH))
    else $error("level fell without a high byte read");

  pair_pop_a: assert property (
    acc_rd && addr_ptr_q == ADDR_READ_HIGH && ring_level != '0
      && !drain_fire |=> ring_level == $past(ring_level) - 8'h01)
    else $error("high byte read did not consume one entry");

  empty_read_a: assert property (
    acc_rd && ring_level == '0 && addr_ptr_q >= ADDR_READ_LOW
      |=> reg_rdata_q == 8'h00 && ring_level <= 8'h01)
    else $error("empty read returned data or moved level");

  irq_follow_a: assert property (
    (ring_level != '0) |=> buffer_data_interrupt_q)
    else $error("interrupt low while entries are held");

  irq_clear_a: assert property (
    (ring_level == '0) |=> !buffer_data_interrupt_q)
    else $error("interrupt high while buffer empty");

  level_range_a: assert property (
    ring_level <= LEVEL_W'(DEPTH))
    else $error("fill level above capacity");

  overflow_set_a: assert property (
    drain_fire && ring_full |=> overflow_flag_q
      && ring_level == $past(ring_level))
    else $error("overflow not flagged or entry stored");

  chan5_mask_a: assert property (
    seq_q == SEQ_IDLE && sample_valid && flicker_detect_enable
      |=> !item_sel_q[SEL_CHAN5_BIT])
    else $error("channel 5 captured with flicker detect on");

  flicker_gate_a: assert property (
    seq_q == SEQ_IDLE && sample_valid
      |=> item_sel_q[SEL_FLICKER_BIT] ==
          $past(cfg_fd_q && flicker_detect_enable))
    else $error("flicker capture gate wrong");

  // selection is latched with the sample, so a map write during a
  // capture cannot split one sample set across two selections
  status_cap_a: assert property (
    seq_q == SEQ_IDLE && sample_valid
      |=> item_sel_q[SEL_STATUS_BIT] == $past(chan_sel_q[SEL_STATUS_BIT]))
    else $error("status capture does not follow its select bit");

  chan_cap_a: assert property (
    seq_q == SEQ_IDLE && sample_valid
      |=> item_sel_q[SEL_CHAN5_BIT-1:SEL_STATUS_BIT+1] ==
          $past(chan_sel_q[SEL_CHAN5_BIT-1:SEL_STATUS_BIT+1]))
    else $error("channel capture does not follow its select bits");

  lone_low_a: assert property (
    acc_rd && addr_ptr_q == ADDR_READ_LOW
      |=> ring_level >= $past(ring_level))
    else $error("low byte read consumed an entry");

  level_step_a: assert property (
    ring_level == $past(ring_level)
      || ring_level == $past(ring_level) + 8'h01
      || ring_level == $past(ring_level) - 8'h01)
    else $error("fill level moved by more than one entry");

  drop_keep_a: assert property (
    drain_fire && ring_full |=> $stable(ring_head))
    else $error("dropped entry disturbed the stored data");

  item_order_a: assert property (
    stage_in_valid && stage_in_ready
      |=> item_q == $past(item_q) + ITEM_STEP)
    else $error("capture items left their fixed order");

  ro_port_a: assert property (
    reg_wr && !reg_rd && !addr_set && addr_ptr_q >= ADDR_READ_LOW
      |=> ring_level >= $past(ring_level))
    else $error("write to the read port consumed an entry");

endmodule : spectral_result_fifo

// ### tb/host_model.sv
module host_model (
  input  wire logic       core_clk,
  output logic            addr_set,
  output logic [7:0]      addr_in,
  output logic            reg_wr,
  output logic [7:0]      reg_wdata,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata_q
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle cycles before each read, so the host can be made slow
  int idle = 0;

  initial begin
    addr_set  = 1'b0;
    addr_in   = 8'h00;
    reg_wr    = 1'b0;
    reg_wdata = 8'h00;
    reg_rd    = 1'b0;
  end

  // released lines show the inverse, never a stale value
  task set_ptr(input logic [7:0] a);
    @(posedge core_clk);
    addr_set <= 1'b1;
    addr_in  <= a;
    @(posedge core_clk);
    addr_set <= 1'b0;
    addr_in  <= ~a;
  endtask : set_ptr

  task rd_next(output logic [7:0] d);
    repeat (idle) @(posedge core_clk);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata_q;
  endtask : rd_next

  task rd_at(input logic [7:0] a, output logic [7:0] d);
    set_ptr(a);
    rd_next(d);
  endtask : rd_at

  task wr_at(input logic [7:0] a, input logic [7:0] v);
    set_ptr(a);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
    reg_wdata <= ~v;
  endtask : wr_at
endmodule : host_model

// ### tb/spectral_result_fifo_tb.sv
module spectral_result_fifo_tb
  import spectral_fifo_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;

  logic               core_clk = 1'b0;
  logic               resetn = 1'b0;
  logic               addr_set;
  logic [7:0]         addr_in;
  logic               reg_wr;
  logic [7:0]         reg_wdata;
  logic               reg_rd;
  logic [7:0]         reg_rdata_q;
  logic               sample_valid = 1'b0;
  logic [7:0]         status_byte = 8'h00;
  logic [ENTRY_W-1:0] chan_data [NUM_CHAN];
  logic [ENTRY_W-1:0] flicker_raw_data = '0;
  logic               flicker_detect_enable = 1'b0;
  logic               overflow_clear = 1'b0;
  logic               overflow_flag_q;
  logic               irq_q;
  logic               capture_busy_q;
  int                 fail_count = 0;
  int                 samples_checked = 0;
  logic [7:0]         rb;

  always #50 core_clk = ~core_clk;

  spectral_result_fifo spectral_result_fifo_inst (
    .core_clk(core_clk), .resetn(resetn), .addr_set(addr_set),
    .addr_in(addr_in), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .sample_valid(sample_valid), .measurement_status_byte(status_byte),
    .chan_data(chan_data), .flicker_raw_data(flicker_raw_data),
    .flicker_detect_enable(flicker_detect_enable),
    .overflow_clear(overflow_clear), .overflow_flag_q(overflow_flag_q),
    .buffer_data_interrupt_q(irq_q), .capture_busy_q(capture_busy_q)
  );

  host_model host_model_inst (
    .core_clk(core_clk), .addr_set(addr_set), .addr_in(addr_in),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata_q(reg_rdata_q)
  );

  task check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task conclude;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude

  task rdchk(input logic [7:0] a, input logic [7:0] exp);
    host_model_inst.rd_at(a, rb);
    check({8'h00, rb}, {8'h00, exp});
  endtask : rdchk

  // reads low then high at the current pointer, relying on the wrap
  task entry(input logic [15:0] exp);
    logic [7:0] lo;
    host_model_inst.rd_next(lo);
    host_model_inst.rd_next(rb);
    check({rb, lo}, exp);
  endtask : entry

  task sample(input logic [7:0] st, input logic [15:0] base);
    int n;
    @(posedge core_clk);
    sample_valid     <= 1'b1;
    status_byte      <= st;
    flicker_raw_data <= base + 16'h0080;
    foreach (chan_data[i]) chan_data[i] <= base + 16'(i);
    @(posedge core_clk);
    sample_valid <= 1'b0;
    repeat (2) @(posedge core_clk);
    // look just after the edge, once the registered flag has settled
    #1;
    check(16'(capture_busy_q), 16'h0001);
    n = 0;
    while (capture_busy_q !== 1'b0 && n < 50) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    if (n == 50) begin
      fail_count++;
      conclude();
    end
    // stage fifo drains into the ring a few cycles after the sequencer
    repeat (4) @(posedge core_clk);
  endtask : sample

  initial begin
    foreach (chan_data[i]) chan_data[i] = '0;
    repeat (6) @(posedge core_clk);
    resetn <= 1'b1;
    rdchk(ADDR_FLICKER_CFG, 8'h21);
    rdchk(ADDR_CHAN_SEL, 8'h00);
    rdchk(ADDR_FILL_LEVEL, 8'h00);
    rdchk(ADDR_READ_LOW, 8'h00);
    rdchk(ADDR_READ_HIGH, 8'h00);
    rdchk(8'h10, 8'h00);
    check(16'(irq_q), 16'h0000);
    host_model_inst.wr_at(ADDR_CHAN_SEL, 8'hFF);
    rdchk(ADDR_CHAN_SEL, 8'h7F);
    host_model_inst.wr_at(ADDR_READ_LOW, 8'h55);
    rdchk(ADDR_READ_LOW, 8'h00);
    host_model_inst.wr_at(ADDR_FLICKER_CFG, {1'b1, CFG_FIXED_BITS});
    rdchk(ADDR_FLICKER_CFG, 8'hA1);
    host_model_inst.wr_at(ADDR_CHAN_SEL, 8'h03);
    sample(8'h5A, 16'h1234);
    rdchk(ADDR_FILL_LEVEL, 8'h02);
    check(16'(irq_q), 16'h0001);
    rdchk(ADDR_READ_LOW, 8'h5A);
    rdchk(ADDR_READ_LOW, 8'h5A);
    rdchk(ADDR_FILL_LEVEL, 8'h02);
    host_model_inst.set_ptr(ADDR_READ_LOW);
    entry(16'h005A);
    entry(16'h1234);
    rdchk(ADDR_FILL_LEVEL, 8'h00);
    repeat (2) @(posedge core_clk);
    check(16'(irq_q), 16'h0000);
    host_model_inst.set_ptr(ADDR_READ_LOW);
    entry(16'h0000);
    entry(16'h0000);
    rdchk(ADDR_FILL_LEVEL, 8'h00);
    // raw flicker bit is set but flicker detection is still off
    host_model_inst.wr_at(ADDR_CHAN_SEL, 8'h7E);
    sample(8'h00, 16'h2000);
    rdchk(ADDR_FILL_LEVEL, 8'h06);
    host_model_inst.set_ptr(ADDR_READ_LOW);
    for (int i = 0; i < 6; i++) entry(16'h2000 + 16'(i));
    @(posedge core_clk);
    flicker_detect_enable <= 1'b1;
    sample(8'h00, 16'h3000);
    rdchk(ADDR_FILL_LEVEL, 8'h06);
    host_model_inst.set_ptr(ADDR_READ_LOW);
    for (int i = 0; i < 5; i++) entry(16'h3000 + 16'(i));
    entry(16'h3080);
    @(posedge core_clk);
    flicker_detect_enable <= 1'b0;
    host_model_inst.wr_at(ADDR_CHAN_SEL, 8'h02);
    for (int i = 0; i < 129; i++) sample(8'h00, 16'h4000 + 16'(i));
    check(16'(overflow_flag_q), 16'h0001);
    rdchk(ADDR_FILL_LEVEL, 8'h80);
    @(posedge core_clk);
    overflow_clear <= 1'b1;
    @(posedge core_clk);
    overflow_clear <= 1'b0;
    repeat (2) @(posedge core_clk);
    check(16'(overflow_flag_q), 16'h0000);
    host_model_inst.idle = 1;
    host_model_inst.set_ptr(ADDR_READ_LOW);
    for (int i = 0; i < 128; i++) entry(16'h4000 + 16'(i));
    entry(16'h0000);
    rdchk(ADDR_FILL_LEVEL, 8'h00);
    conclude();
  end
endmodule : spectral_result_fifo_tb
